// >>> rtl/smp_parser.sv
// Functional notes
// - Operation and questionable groups each hold condition, enable and event registers.
// - Calibration mode opens only after the correct access code is given.
// - Voltage and current calibrations have zero and full steps; saved to store.
// - Remote calibration cannot be opened while front panel calibration is active.
// - Voltage step updates three voltage constants; current step three current ones.
// - Message units are acted on only after the terminator arrives.
// - Short form is whole word up to four letters, else three or four.
// - Any other spelling or truncation of a keyword is an error.
// - Keyword letters match regardless of case.
// - A colon between keywords moves one level down the tree, except after SOURCE at the root, which is skipped.
// - A question mark after the last keyword makes the unit a query.
// - A parameter follows the last keyword after a space.
// - Semicolons separate message units within one message.
// - Only the new line character terminates a message.
// - Terminator or leading root colon returns the parser to the root.
`timescale 1ns/1ps
`include "smp_regs.svh"
module smp_parser #(
  parameter int          DEPTH    = 8,
  parameter logic [15:0] CAL_CODE = `SMP_CAL_CODE
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  // Character stream from the controller
  input  wire logic         char_valid_in,
  input  wire logic [7:0]   char_in,
  output logic              char_ready_out,
  // Status conditions and summaries
  input  wire logic [15:0]  oper_cond_in,
  input  wire logic [15:0]  ques_cond_in,
  output logic              oper_summary_out,
  output logic              ques_summary_out,
  // Calibration
  input  wire logic         fp_cal_active_in,
  output logic              remote_cal_out,
  output logic              nv_wr_out,
  output logic [2:0]        nv_addr_out,
  output logic [31:0]       nv_data_out,
  // Responses and errors
  output logic              resp_valid_out,
  output logic [15:0]       resp_data_out,
  output logic              kw_err_out,
  output logic              exec_err_out,
  output logic              msg_done_out
);
  if (DEPTH < 2 || DEPTH > 15) begin : g_bad_depth
    $error("DEPTH must lie between 2 and 15");
  end
  // ==========================================================================
  // State.
  typedef struct packed {
    smp_pkg::smp_fsm_e       fsm;
    logic [95:0]             kw;
    logic [3:0]              kwlen;
    smp_pkg::smp_kw_t [3:0]  path;
    logic [2:0]              lvl;
    logic [2:0]              base;
    logic                    query;
    logic                    has_param;
    logic [15:0]             param;
    logic                    bad;
    logic [3:0]              ucnt;
    logic [3:0]              idx;
    logic                    rd_ph;
    smp_pkg::smp_stat_s      oper;
    smp_pkg::smp_stat_s      ques;
    logic                    cal_on;
    logic                    v_done;
    logic                    i_done;
    logic [15:0]             vz;
    logic [15:0]             vf;
    logic [15:0]             iz;
    logic [15:0]             ifl;
    logic [2:0]              sv;
    logic                    resp_valid;
    logic [15:0]             resp_data;
    logic                    kw_err;
    logic                    exec_err;
    logic                    msg_done;
    logic                    nv_wr;
    logic [2:0]              nv_addr;
    logic [31:0]             nv_data;
  } smp_state_s;
  smp_state_s          s_q;
  smp_state_s          s_d;
  logic                acc;
  logic                wr_en;
  smp_pkg::smp_unit_s  wr_unit;
  smp_pkg::smp_unit_s  rd_unit;
  // ==========================================================================
  // Keyword lookup. Incoming letters are folded to upper case on entry.
  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
  endfunction
  function automatic logic is_letter(input logic [7:0] c);
    is_letter = (upcase(c) >= 8'h41) && (upcase(c) <= 8'h5A);
  endfunction
  function automatic smp_pkg::smp_kw_t kw_find(input logic [95:0] k, input logic [3:0] n);
    logic [95:0] t;
    logic [3:0]  ln;
    logic [3:0]  sl;
    logic [7:0]  c4;
    kw_find = `SMP_KW_NONE;
    for (int e = 0; e < smp_pkg::KW_N; e++) begin
      t  = smp_pkg::KW_TAB[e];
      ln = 4'h0;
      for (int b = 0; b < 12; b++) begin
        if (t[8*b+:8] != 8'h00) ln = 4'(b + 1);
      end
      c4 = (ln >= 4'h4) ? t[8*(ln-4'h4)+:8] : 8'h00;
      if (ln <= 4'h4) sl = ln;
      else if (c4 == "A" || c4 == "E" || c4 == "I" || c4 == "O" || c4 == "U") sl = 4'h3;
      else sl = 4'h4;
      // Only the full spelling or the exact short form matches.
      if (n != 4'h0 && ((n == ln && k == t) || (n == sl && (t >> (8*(ln-n))) == k))) begin
        kw_find = 5'(e + 1);
      end
    end
  endfunction
  // ==========================================================================
  // Next state.
  always_comb begin
    logic [7:0]          c;
    smp_pkg::smp_kw_t    id;
    logic                err;
    logic                fin;
    logic                unit_end;
    logic                end_msg;
    logic                last;
    smp_pkg::smp_unit_s  u;
    logic [15:0]         sel;
    s_d = s_q;
    c = char_in;
    id = kw_find(s_q.kw, s_q.kwlen);
    err = 1'b0;
    fin = 1'b0;
    unit_end = 1'b0;
    end_msg = 1'b0;
    last = (5'(s_q.idx) + 5'h01 >= 5'(s_q.ucnt));
    u = rd_unit;
    sel = 16'h0000;
    wr_en = 1'b0;
    wr_unit = '0;
    s_d.resp_valid = 1'b0;
    s_d.kw_err = 1'b0;
    s_d.exec_err = 1'b0;
    s_d.msg_done = 1'b0;
    s_d.nv_wr = 1'b0;
    unique case (s_q.fsm)
      smp_pkg::SMP_KW_ST: begin
        if (acc) begin
          if (is_letter(c) && !s_q.query && s_q.kwlen < `SMP_KW_MAXLEN) begin
            s_d.kw = {s_q.kw[87:0], upcase(c)};
            s_d.kwlen = s_q.kwlen + 4'h1;
          end else if (c == `SMP_CH_COLON && s_q.kwlen == 4'h0 && s_q.lvl == s_q.base && !s_q.query) begin
            s_d.lvl = 3'h0;
            s_d.base = 3'h0;
          end else if (c == `SMP_CH_COLON && s_q.kwlen != 4'h0 && !s_q.query) begin
            fin = 1'b1;
          end else if (c == `SMP_CH_QUERY && s_q.kwlen != 4'h0 && !s_q.query) begin
            fin = 1'b1;
            s_d.query = 1'b1;
          end else if (c == `SMP_CH_SPACE && (s_q.kwlen != 4'h0 || s_q.query)) begin
            fin = (s_q.kwlen != 4'h0);
            s_d.fsm = smp_pkg::SMP_PARAM;
          end else if (c == `SMP_CH_SEMI || c == `SMP_CH_NL) begin
            fin = (s_q.kwlen != 4'h0);
            unit_end = 1'b1;
          end else if (c != `SMP_CH_CR) begin
            err = 1'b1;
          end
        end
      end
      smp_pkg::SMP_PARAM: begin
        if (acc) begin
          if (c >= 8'h30 && c <= 8'h39) begin
            s_d.param = 16'(s_q.param * 16'd10 + {8'h00, c - 8'h30});
            s_d.has_param = 1'b1;
          end else if (c == `SMP_CH_SEMI || c == `SMP_CH_NL) begin
            unit_end = 1'b1;
          end else if (c == `SMP_CH_COLON || c == `SMP_CH_QUERY) begin
            err = 1'b1;
          end else if (c != `SMP_CH_SPACE && c != `SMP_CH_CR) begin
            s_d.has_param = 1'b1;
          end
        end
      end
      smp_pkg::SMP_SKIP: begin
        end_msg = acc && (c == `SMP_CH_NL);
      end
      smp_pkg::SMP_EXEC: begin
        s_d.rd_ph = !s_q.rd_ph;
        if (s_q.rd_ph) begin
          s_d.idx = s_q.idx + 4'h1;
          if (u.path[0] == `SMP_KW_STAT && u.depth == 3'h3 &&
              (u.path[1] == `SMP_KW_OPER || u.path[1] == `SMP_KW_QUES)) begin
            sel = (u.path[2] == `SMP_KW_COND) ? (u.path[1] == `SMP_KW_OPER ? s_q.oper.cond : s_q.ques.cond) :
                  (u.path[2] == `SMP_KW_ENAB) ? (u.path[1] == `SMP_KW_OPER ? s_q.oper.enab : s_q.ques.enab) :
                  (u.path[1] == `SMP_KW_OPER ? s_q.oper.event_r : s_q.ques.event_r);
            if (u.query && u.path[2] != `SMP_KW_NONE) begin
              s_d.resp_valid = 1'b1;
              s_d.resp_data = sel;
              if (u.path[2] == `SMP_KW_EVEN && u.path[1] == `SMP_KW_OPER) s_d.oper.event_r = 16'h0000;
              if (u.path[2] == `SMP_KW_EVEN && u.path[1] == `SMP_KW_QUES) s_d.ques.event_r = 16'h0000;
            end else if (u.path[2] == `SMP_KW_ENAB && u.has_param) begin
              if (u.path[1] == `SMP_KW_OPER) s_d.oper.enab = u.param;
              else s_d.ques.enab = u.param;
            end else begin
              s_d.exec_err = 1'b1;
            end
          end else if (u.path[0] == `SMP_KW_CAL && u.path[1] == `SMP_KW_CODE && u.has_param) begin
            if (u.param == CAL_CODE && !fp_cal_active_in) s_d.cal_on = 1'b1;
            else s_d.exec_err = 1'b1;
          end else if (u.path[0] == `SMP_KW_CAL && !s_q.cal_on) begin
            s_d.exec_err = 1'b1;
          end else if (u.path[0] == `SMP_KW_CAL && u.depth == 3'h3 && u.has_param &&
                       (u.path[1] == `SMP_KW_VOLT || u.path[1] == `SMP_KW_CURR)) begin
            // Either group may be calibrated alone before saving.
            if (u.path[1] == `SMP_KW_VOLT && u.path[2] == `SMP_KW_ZERO) s_d.vz = u.param;
            else if (u.path[1] == `SMP_KW_VOLT && u.path[2] == `SMP_KW_FULL) s_d.vf = u.param;
            else if (u.path[2] == `SMP_KW_ZERO) s_d.iz = u.param;
            else if (u.path[2] == `SMP_KW_FULL) s_d.ifl = u.param;
            else s_d.exec_err = 1'b1;
            if (u.path[1] == `SMP_KW_VOLT && u.path[2] == `SMP_KW_FULL) s_d.v_done = 1'b1;
            if (u.path[1] == `SMP_KW_CURR && u.path[2] == `SMP_KW_FULL) s_d.i_done = 1'b1;
          end else if (u.path[0] == `SMP_KW_CAL && u.path[1] == `SMP_KW_SAVE && u.depth == 3'h2) begin
            s_d.fsm = smp_pkg::SMP_SAVE;
            s_d.sv = 3'h0;
          end else begin
            s_d.exec_err = 1'b1;
          end
          if (last && s_d.fsm == smp_pkg::SMP_EXEC) begin
            s_d.fsm = smp_pkg::SMP_KW_ST;
            s_d.ucnt = 4'h0;
            s_d.msg_done = 1'b1;
          end
        end
      end
      smp_pkg::SMP_SAVE: begin
        // Each group whose full step was taken writes its setting, protection and readback constant.
        s_d.nv_wr = (s_q.sv < 3'h3) ? s_q.v_done : s_q.i_done;
        s_d.nv_addr = s_q.sv;
        s_d.nv_data = (s_q.sv < 3'h3) ? {16'(s_q.vf - s_q.vz), s_q.vz} : {16'(s_q.ifl - s_q.iz), s_q.iz};
        s_d.sv = s_q.sv + 3'h1;
        if (s_q.sv == `SMP_NV_IRB) begin
          s_d.cal_on = 1'b0;
          s_d.v_done = 1'b0;
          s_d.i_done = 1'b0;
          s_d.rd_ph = 1'b0;
          s_d.fsm = (s_q.idx >= s_q.ucnt) ? smp_pkg::SMP_KW_ST : smp_pkg::SMP_EXEC;
          s_d.msg_done = (s_q.idx >= s_q.ucnt);
          if (s_q.idx >= s_q.ucnt) s_d.ucnt = 4'h0;
        end
      end
    endcase
    if (fin) begin
      if (id == `SMP_KW_NONE || s_q.lvl >= `SMP_PATH_DEPTH) begin
        err = 1'b1;
      end else if (!(id == `SMP_KW_SOUR && s_q.lvl == 3'h0)) begin
        s_d.path[s_q.lvl[1:0]] = id;
        s_d.lvl = s_q.lvl + 3'h1;
      end
      s_d.kw = '0;
      s_d.kwlen = 4'h0;
    end
    if (err) begin
      s_d.kw_err = 1'b1;
      s_d.bad = 1'b1;
      s_d.fsm = smp_pkg::SMP_SKIP;
      end_msg = (c == `SMP_CH_NL);
    end else if (unit_end) begin
      // Units are only queued here; nothing acts before the terminator.
      if (s_d.lvl != s_q.base) begin
        wr_en = !s_q.bad && (s_q.ucnt < 4'(DEPTH));
        wr_unit.path = s_d.path;
        wr_unit.depth = s_d.lvl;
        wr_unit.query = s_d.query;
        wr_unit.has_param = s_d.has_param;
        wr_unit.param = s_d.param;
        s_d.ucnt = s_q.ucnt + 4'h1;
        if (s_q.ucnt >= 4'(DEPTH)) s_d.bad = 1'b1;
      end
      s_d.lvl = (s_d.lvl == 3'h0) ? 3'h0 : s_d.lvl - 3'h1;
      s_d.base = s_d.lvl;
      s_d.query = 1'b0;
      s_d.has_param = 1'b0;
      s_d.param = 16'h0000;
      s_d.fsm = smp_pkg::SMP_KW_ST;
      end_msg = (c == `SMP_CH_NL);
    end
    if (end_msg) begin
      s_d.lvl = 3'h0;
      s_d.base = 3'h0;
      s_d.kw = '0;
      s_d.kwlen = 4'h0;
      s_d.query = 1'b0;
      s_d.has_param = 1'b0;
      s_d.param = 16'h0000;
      s_d.idx = 4'h0;
      s_d.rd_ph = 1'b0;
      if (s_d.bad || s_d.ucnt == 4'h0) begin
        s_d.ucnt = 4'h0;
        s_d.bad = 1'b0;
        s_d.msg_done = 1'b1;
        s_d.fsm = smp_pkg::SMP_KW_ST;
      end else begin
        s_d.fsm = smp_pkg::SMP_EXEC;
      end
    end
    // New events are merged after any clear so that a set wins.
    s_d.oper.cond = oper_cond_in;
    s_d.ques.cond = ques_cond_in;
    s_d.oper.event_r = s_d.oper.event_r | (oper_cond_in & ~s_q.oper.cond);
    s_d.ques.event_r = s_d.ques.event_r | (ques_cond_in & ~s_q.ques.cond);
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
      s_q.fsm <= smp_pkg::SMP_KW_ST;
      s_q.oper.enab <= `SMP_RST_ENAB;
      s_q.ques.enab <= `SMP_RST_ENAB;
    end else begin
      s_q <= s_d;
    end
  end
  // ==========================================================================
  // Unit queue and outputs.
  smp_unit_mem #(.DEPTH(DEPTH)) u_mem (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .wr_en_in    (wr_en),
    .wr_addr_in  (s_q.ucnt),
    .wr_data_in  (wr_unit),
    .rd_addr_in  (s_q.idx),
    .rd_data_out (rd_unit)
  );
  assign char_ready_out   = s_q.fsm inside {smp_pkg::SMP_KW_ST, smp_pkg::SMP_PARAM, smp_pkg::SMP_SKIP};
  assign acc              = char_valid_in && char_ready_out;
  assign oper_summary_out = |(s_q.oper.event_r & s_q.oper.enab);
  assign ques_summary_out = |(s_q.ques.event_r & s_q.ques.enab);
  assign remote_cal_out   = s_q.cal_on;
  assign nv_wr_out        = s_q.nv_wr;
  assign nv_addr_out      = s_q.nv_addr;
  assign nv_data_out      = s_q.nv_data;
  assign resp_valid_out   = s_q.resp_valid;
  assign resp_data_out    = s_q.resp_data;
  assign kw_err_out       = s_q.kw_err;
  assign exec_err_out     = s_q.exec_err;
  assign msg_done_out     = s_q.msg_done;
  // ==========================================================================
  // Checks.
  logic id_ok;
  logic sour0;
  assign id_ok = (kw_find(s_q.kw, s_q.kwlen) != `SMP_KW_NONE);
  assign sour0 = (kw_find(s_q.kw, s_q.kwlen) == `SMP_KW_SOUR) && (s_q.lvl == 3'h0);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_nl_taken;
    acc && char_in == `SMP_CH_NL;
  endsequence
  sequence s_kw_colon;
    acc && s_q.fsm == smp_pkg::SMP_KW_ST && char_in == `SMP_CH_COLON && s_q.kwlen != 4'h0 && !s_q.query;
  endsequence
  // A save in mid-message resumes execution without a new terminator.
  chk_exec_after_nl: assert property ($rose(s_q.fsm == smp_pkg::SMP_EXEC) |->
    $past(acc && char_in == `SMP_CH_NL) || $past(s_q.fsm == smp_pkg::SMP_SAVE))
    else $error("execution began without a terminator");
  chk_root_on_nl: assert property (s_nl_taken |=> s_q.lvl == 3'h0 && s_q.base == 3'h0)
    else $error("terminator did not return to root");
  chk_colon_down: assert property (s_kw_colon ##0 (id_ok && s_q.lvl < 3'h4 && !sour0) |=> s_q.lvl == $past(s_q.lvl) + 3'h1)
    else $error("keyword separator did not descend one level");
  chk_bad_kw_err: assert property (s_kw_colon ##0 !id_ok |=> kw_err_out ##1 !kw_err_out)
    else $error("malformed keyword not flagged once");
  chk_param_space: assert property ($rose(s_q.fsm == smp_pkg::SMP_PARAM) |-> $past(char_in) == `SMP_CH_SPACE)
    else $error("parameter entered without a space");
  chk_unit_delim: assert property (wr_en |-> acc && (char_in == `SMP_CH_SEMI || char_in == `SMP_CH_NL))
    else $error("unit queued without a delimiter");
  chk_cal_gate: assert property ($rose(s_q.cal_on) |-> $past(rd_unit.param == CAL_CODE && !fp_cal_active_in))
    else $error("calibration opened without the access code");
  chk_cal_exclusive: assert property ($rose(s_q.cal_on) |-> $past(s_q.fsm == smp_pkg::SMP_EXEC) && !$past(fp_cal_active_in))
    else $error("remote calibration opened during local calibration");
  chk_event_sticky: assert property ($rose(oper_cond_in[1]) |=> s_q.oper.event_r[1] ##1 s_q.oper.event_r[1] || resp_valid_out)
    else $error("operation event not latched");
  chk_save_walk: assert property ($rose(s_q.fsm == smp_pkg::SMP_SAVE) |=> nv_addr_out == `SMP_NV_VSET ##5 nv_addr_out == `SMP_NV_IRB)
    else $error("calibration save sequence wrong");
endmodule // smp_parser

// >>> rtl/smp_pkg.sv
package smp_pkg;
  typedef logic [4:0] smp_kw_t;
  typedef struct packed {
    smp_kw_t [3:0] path;
    logic [2:0]    depth;
    logic          query;
    logic          has_param;
    logic [15:0]   param;
  } smp_unit_s;
  typedef struct packed {
    logic [15:0] cond;
    logic [15:0] enab;
    logic [15:0] event_r;
  } smp_stat_s;
  typedef enum logic [4:0] {
    SMP_KW_ST   = 5'b00001,
    SMP_PARAM   = 5'b00010,
    SMP_SKIP    = 5'b00100,
    SMP_EXEC    = 5'b01000,
    SMP_SAVE    = 5'b10000
  } smp_fsm_e;
  localparam int KW_N = 14;
  localparam logic [0:KW_N-1][95:0] KW_TAB = '{
    96'("STATUS"), 96'("OPERATION"), 96'("QUESTIONABLE"), 96'("CONDITION"), 96'("ENABLE"),
    96'("EVENT"), 96'("CALIBRATE"), 96'("VOLTAGE"), 96'("CURRENT"), 96'("ZERO"),
    96'("FULL"), 96'("CODE"), 96'("SAVE"), 96'("SOURCE")};
endpackage

// >>> rtl/smp_regs.svh
`ifndef SMP_REGS_SVH
`define SMP_REGS_SVH
// ==========================================================================
// Characters of the message syntax.
`define SMP_CH_NL      8'h0A
`define SMP_CH_CR      8'h0D
`define SMP_CH_SPACE   8'h20
`define SMP_CH_COLON   8'h3A
`define SMP_CH_SEMI    8'h3B
`define SMP_CH_QUERY   8'h3F
// ==========================================================================
// Keyword identifiers, index into the keyword table plus one.
`define SMP_KW_NONE    5'h00
`define SMP_KW_STAT    5'h01
`define SMP_KW_OPER    5'h02
`define SMP_KW_QUES    5'h03
`define SMP_KW_COND    5'h04
`define SMP_KW_ENAB    5'h05
`define SMP_KW_EVEN    5'h06
`define SMP_KW_CAL     5'h07
`define SMP_KW_VOLT    5'h08
`define SMP_KW_CURR    5'h09
`define SMP_KW_ZERO    5'h0A
`define SMP_KW_FULL    5'h0B
`define SMP_KW_CODE    5'h0C
`define SMP_KW_SAVE    5'h0D
`define SMP_KW_SOUR    5'h0E
// ==========================================================================
// Limits, reset values and calibration store layout.
`define SMP_KW_MAXLEN  4'hC
`define SMP_PATH_DEPTH 3'h4
`define SMP_RST_ENAB   16'h0000
`define SMP_CAL_CODE   16'h0000
`define SMP_NV_VSET    3'h0
`define SMP_NV_VOVP    3'h1
`define SMP_NV_VRB     3'h2
`define SMP_NV_ISET    3'h3
`define SMP_NV_IOCP    3'h4
`define SMP_NV_IRB     3'h5
`endif

// >>> rtl/smp_unit_mem.sv
`timescale 1ns/1ps
module smp_unit_mem #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                resetn_in,
  // Write side
  input  wire logic                wr_en_in,
  input  wire logic [3:0]          wr_addr_in,
  input  wire smp_pkg::smp_unit_s  wr_data_in,
  // Read side, one cycle latency
  input  wire logic [3:0]          rd_addr_in,
  output smp_pkg::smp_unit_s       rd_data_out
);
  if (DEPTH < 1 || DEPTH > 16) begin : g_bad_depth
    $error("DEPTH must lie between 1 and 16");
  end
  typedef struct packed {
    smp_pkg::smp_unit_s [DEPTH-1:0] mem;
    smp_pkg::smp_unit_s             rd;
  } smp_mem_s;
  smp_mem_s s_q;
  smp_mem_s s_d;
  always_comb begin
    s_d = s_q;
    if (wr_en_in && (int'(wr_addr_in) < DEPTH)) begin
      s_d.mem[wr_addr_in] = wr_data_in;
    end
    s_d.rd = (int'(rd_addr_in) < DEPTH) ? s_q.mem[rd_addr_in] : '0;
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign rd_data_out = s_q.rd;
endmodule // smp_unit_mem

// >>> verif/smp_ctrl_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Controller model: offers message text one character at a time.
module smp_ctrl_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // Character stream towards the parser
  input  wire logic       char_ready_in,
  output logic            char_valid_out,
  output logic [7:0]      char_out
);
  initial begin
    char_valid_out = 1'b0;
    char_out       = 8'hA5;
  end
  // Caller enters just after a rising edge. Each character is held until taken.
  // With a nonzero gap the data lines toggle between characters so stale values are never reused.
  task automatic send(input string s, input int gap);
    for (int i = 0; i < s.len(); i++) begin
      char_valid_out = 1'b1;
      char_out       = s[i];
      do @(posedge clk_in); while (char_ready_in !== 1'b1);
      #2;
      if (gap > 0) begin
        char_valid_out = 1'b0;
        char_out       = ~char_out;
        repeat (gap) @(posedge clk_in);
        #2;
      end
    end
    char_valid_out = 1'b0;
    char_out       = ~char_out;
  endtask
endmodule // smp_ctrl_model

// >>> verif/smp_parser_tb.sv
`timescale 1ns/1ps
module smp_parser_tb;
  logic clk_in, resetn_in, char_valid_in, char_ready_out, fp_cal_active_in;
  logic [7:0] char_in;
  logic [15:0] oper_cond_in, ques_cond_in, resp_data_out;
  logic oper_summary_out, ques_summary_out, remote_cal_out, nv_wr_out;
  logic resp_valid_out, kw_err_out, exec_err_out, msg_done_out;
  logic [2:0] nv_addr_out;
  logic [31:0] nv_data_out, nv_last;
  logic [7:0] nv_mask;
  int num_errors, checks_done, n_resp, n_kw, n_exec, n_done;
  string forms[8] = '{"STATUS:OPERATION:ENABLE", "stat:oper:enab", "StAt:QuEs:EnAbLe", "STAT:QUESTIONABLE:ENAB",
                      "STATU:OPER:ENAB", "STAT:OPER:ENABL", "STA:OPER:ENAB", "STAT:QUESTION:ENAB"};
  smp_parser #(.DEPTH(8), .CAL_CODE(16'h1234)) uut (.clk_in(clk_in), .resetn_in(resetn_in),
    .char_valid_in(char_valid_in), .char_in(char_in), .char_ready_out(char_ready_out),
    .oper_cond_in(oper_cond_in), .ques_cond_in(ques_cond_in), .oper_summary_out(oper_summary_out),
    .ques_summary_out(ques_summary_out), .fp_cal_active_in(fp_cal_active_in), .remote_cal_out(remote_cal_out),
    .nv_wr_out(nv_wr_out), .nv_addr_out(nv_addr_out), .nv_data_out(nv_data_out), .resp_valid_out(resp_valid_out),
    .resp_data_out(resp_data_out), .kw_err_out(kw_err_out), .exec_err_out(exec_err_out),
    .msg_done_out(msg_done_out));
  smp_ctrl_model m (.clk_in(clk_in), .resetn_in(resetn_in), .char_ready_in(char_ready_out),
    .char_valid_out(char_valid_in), .char_out(char_in));
  // ==========================================================================
  // Clock, watchdog and pulse monitor
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    #(100000 * 25);
    num_errors++;
    finish_test();
  end
  always @(posedge clk_in) begin
    if (resp_valid_out === 1'b1) n_resp++;
    if (kw_err_out === 1'b1) n_kw++;
    if (exec_err_out === 1'b1) n_exec++;
    if (msg_done_out === 1'b1) n_done++;
    if (nv_wr_out === 1'b1) begin
      nv_mask[nv_addr_out] = 1'b1;
      nv_last              = nv_data_out;
    end
  end
  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic clr();
    {n_resp, n_kw, n_exec, n_done} = '0;
    nv_mask = 8'h00;
  endtask
  task automatic wait_done();
    repeat (400) begin
      @(posedge clk_in);
      #2;
      if (n_done > 0) break;
    end
    check("msg_done", n_done, 1);
  endtask
  task automatic run(input string s, input int gap);
    clr();
    m.send(s, gap);
    wait_done();
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_forms();
    for (int k = 0; k < 8; k++) begin
      run($sformatf("%s %0d;ENAB?\n", forms[k], k + 1), k % 2);
      check("form_err", n_kw, (k > 3) ? 1 : 0);
      check("form_resp", n_resp, (k > 3) ? 0 : 1);
      if (k < 4) check("form_val", resp_data_out, k + 1);
    end
  endtask
  task automatic t_status();
    oper_cond_in = 16'h0012;
    repeat (3) @(posedge clk_in);
    #2;
    run("STAT:OPER:ENAB 2;COND?\n", 3);
    check("cond", resp_data_out, 16'h0012);
    check("summary", {oper_summary_out, ques_summary_out}, 2'b10);
    run("STAT:OPER:EVEN?\n", 0);
    check("event", resp_data_out, 16'h0012);
    run("STAT:OPER:EVEN?\n", 0);
    check("event_clr", resp_data_out, 16'h0000);
    check("summary_clr", oper_summary_out, 1'b0);
  endtask
  task automatic t_tree();
    run("STAT:QUES:ENAB 9;:STAT:OPER:ENAB 4;ENAB?\n", 0);
    check("root_unit", resp_data_out, 16'h0004);
    run("STAT:QUES:ENAB?\n", 0);
    check("first_unit", resp_data_out, 16'h0009);
    run("ENAB?\n", 0);
    check("root_reset", n_resp, 0);
    check("root_err", n_kw + n_exec, 1);
  endtask
  task automatic t_term();
    clr();
    m.send("STAT:OPER:ENAB?", 0);
    repeat (20) @(posedge clk_in);
    #2;
    check("no_term", n_resp, 0);
    m.send("\r", 0);
    repeat (20) @(posedge clk_in);
    #2;
    check("cr_term", n_resp, 0);
    m.send("\n", 0);
    wait_done();
    check("nl_term", n_resp, 1);
    check("nl_val", resp_data_out, 16'h0004);
    run("STAT:OPER:ENAB5\n", 0);
    check("no_space", n_kw, 1);
  endtask
  task automatic t_cal();
    run("CAL:VOLT:ZERO 5\n", 0);
    check("cal_locked", n_exec, 1);
    run("CAL:CODE 4661\n", 0);
    check("bad_code", n_exec, 1);
    check("bad_code_cal", remote_cal_out, 1'b0);
    fp_cal_active_in = 1'b1;
    run("CAL:CODE 4660\n", 0);
    check("fp_mix", n_exec, 1);
    check("fp_mix_cal", remote_cal_out, 1'b0);
    fp_cal_active_in = 1'b0;
    run("CALI:CODE 4660\n", 0);
    check("cal_short", n_kw, 1);
    run(":CAL:CODE 4660\n", 2);
    check("cal_open", remote_cal_out, 1'b1);
    run("CAL:VOLT:ZERO 100;FULL 600\n", 0);
    check("cal_steps", n_exec + n_kw, 0);
    run("CAL:SAVE\n", 0);
    repeat (6) @(posedge clk_in);
    #2;
    check("nv_addr", nv_mask, 8'h07);
    check("nv_data", nv_last, 32'h01F40064);
    check("cal_close", remote_cal_out, 1'b0);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    {num_errors, checks_done} = '0;
    clr();
    resetn_in        = 1'b0;
    oper_cond_in     = 16'h0000;
    ques_cond_in     = 16'h0000;
    fp_cal_active_in = 1'b0;
    repeat (16) @(posedge clk_in);
    #2;
    resetn_in = 1'b1;
    t_forms();
    t_status();
    t_tree();
    t_term();
    t_cal();
    finish_test();
  end
endmodule // smp_parser_tb
